/* File: verilog/fwr_device.sv */
module fwr_device #(
   parameter int NUM_WARN = fwr_pkg::NW
) (
   input wire logic CORE_CLK_I, // core clock
   input wire logic RST_B_I, // async reset, low
   fwr_link_if.dev LINK, // register and alarm link
   input wire logic [fwr_pkg::NF-1:0] FAULT_COND_I, // fault detectors
   input wire logic [NUM_WARN-1:0] WARN_COND_I, // warning detectors
   input wire logic GATE_CMD_I, // pwm command
   output logic SOURCE_OUTPUT_O, // high side on
   output logic SINK_OUTPUT_O, // low side on
   output logic LINK_ENABLED_O // register link accepted
);
   localparam int NF = fwr_pkg::NF;
   localparam int DW = fwr_pkg::DW;

   logic [NF+NUM_WARN:0] sync_q;
   logic [NF-1:0] fault_cond;
   logic [NUM_WARN-1:0] warn_cond;
   logic gate_cmd;

   fwr_sync #(.W(NF + NUM_WARN + 1)) u_sync (
      .clk_i(CORE_CLK_I),
      .rst_b_i(RST_B_I),
      .d_i({GATE_CMD_I, WARN_COND_I, FAULT_COND_I}),
      .q_o(sync_q)
   );
   assign fault_cond = sync_q[NF-1:0];
   assign warn_cond = sync_q[NF+NUM_WARN-1:NF];
   assign gate_cmd = sync_q[NF+NUM_WARN];

   // register and link state
   logic ack_ff, nxt_ack_ff;
   logic err_ff, nxt_err_ff;
   logic [DW-1:0] rdata_ff, nxt_rdata_ff;
   logic [NF-1:0] fault_mask_ff, nxt_fault_mask_ff;
   logic [NUM_WARN-1:0] warn_mask_ff, nxt_warn_mask_ff;
   logic [2*NF-1:0] safe_ff, nxt_safe_ff;
   logic clr_ff, nxt_clr_ff;
   // flag state
   logic [NF-1:0] fault_flag_ff, nxt_fault_flag_ff;
   logic [NUM_WARN-1:0] warn_prev_ff, nxt_warn_prev_ff;
   logic [NUM_WARN-1:0] warn_pend_ff, nxt_warn_pend_ff;
   logic falarm_n_ff, nxt_falarm_n_ff;
   logic walarm_n_ff, nxt_walarm_n_ff;
   // output state
   logic source_ff, nxt_source_ff;
   logic sink_ff, nxt_sink_ff;
   logic link_en_ff, nxt_link_en_ff;

   logic take;
   logic warn_rd;
   logic [NF-1:0] fault_act;
   logic [NF-1:0] force_low;
   logic [NF-1:0] force_high;

   // primary supply loss cuts the register link, not latched
   assign take = LINK.req && !ack_ff;
   assign warn_rd = take && link_en_ff && !LINK.we && LINK.addr == fwr_pkg::REG_WARN_STAT;

   always_comb begin
      nxt_ack_ff = take;
      nxt_err_ff = take && !link_en_ff;
      nxt_rdata_ff = rdata_ff;
      nxt_fault_mask_ff = fault_mask_ff;
      nxt_warn_mask_ff = warn_mask_ff;
      nxt_safe_ff = safe_ff;
      nxt_clr_ff = 1'b0;
      nxt_link_en_ff = !(fault_cond[fwr_pkg::F_PRI_UV] || fault_cond[fwr_pkg::F_PRI_OV]);
      if (take && link_en_ff) begin
         nxt_rdata_ff = '0;
         if (LINK.we) begin
            case (LINK.addr)
               fwr_pkg::REG_FAULT_MASK: nxt_fault_mask_ff = LINK.wdata[NF-1:0];
               fwr_pkg::REG_WARN_MASK: nxt_warn_mask_ff = LINK.wdata[NUM_WARN-1:0];
               fwr_pkg::REG_SAFE_STATE: nxt_safe_ff = LINK.wdata[2*NF-1:0];
               fwr_pkg::REG_CONTROL: nxt_clr_ff = LINK.wdata[fwr_pkg::CLR_BIT];
               default: nxt_rdata_ff = '0;
            endcase
         end else begin
            case (LINK.addr)
               fwr_pkg::REG_FAULT_STAT: nxt_rdata_ff[NF-1:0] = fault_flag_ff;
               fwr_pkg::REG_WARN_STAT: nxt_rdata_ff[NUM_WARN-1:0] = warn_cond;
               fwr_pkg::REG_FAULT_MASK: nxt_rdata_ff[NF-1:0] = fault_mask_ff;
               fwr_pkg::REG_WARN_MASK: nxt_rdata_ff[NUM_WARN-1:0] = warn_mask_ff;
               fwr_pkg::REG_SAFE_STATE: nxt_rdata_ff[2*NF-1:0] = safe_ff;
               fwr_pkg::REG_CONTROL: nxt_rdata_ff[fwr_pkg::CLR_BIT] = clr_ff;
               fwr_pkg::REG_WARN_PEND: nxt_rdata_ff[NUM_WARN-1:0] = warn_pend_ff;
               default: nxt_rdata_ff = '0;
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         rdata_ff <= '0;
         fault_mask_ff <= fwr_pkg::FAULT_MASK_RST;
         warn_mask_ff <= '0;
         safe_ff <= fwr_pkg::SAFE_STATE_RST;
         clr_ff <= 1'b0;
         link_en_ff <= 1'b1;
      end else begin
         ack_ff <= nxt_ack_ff;
         err_ff <= nxt_err_ff;
         rdata_ff <= nxt_rdata_ff;
         fault_mask_ff <= nxt_fault_mask_ff;
         warn_mask_ff <= nxt_warn_mask_ff;
         safe_ff <= nxt_safe_ff;
         clr_ff <= nxt_clr_ff;
         link_en_ff <= nxt_link_en_ff;
      end
   end

   // a live condition wins over a clear in the same cycle
   always_comb begin
      nxt_fault_flag_ff = (fault_flag_ff & ~{NF{clr_ff}}) | fault_cond;
      // primary supply flags follow the supply, no latch
      nxt_fault_flag_ff[fwr_pkg::F_PRI_UV] = fault_cond[fwr_pkg::F_PRI_UV];
      nxt_fault_flag_ff[fwr_pkg::F_PRI_OV] = fault_cond[fwr_pkg::F_PRI_OV];
      nxt_warn_prev_ff = warn_cond;
      // edge set so a cleared warning waits for a fresh occurrence
      nxt_warn_pend_ff = (warn_cond & ~warn_prev_ff) |
                         (warn_pend_ff & ~{NUM_WARN{warn_rd}});
      nxt_falarm_n_ff = !(|(nxt_fault_flag_ff & ~fault_mask_ff));
      nxt_walarm_n_ff = !(|(nxt_warn_pend_ff & ~warn_mask_ff));
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fault_flag_ff <= '0;
         warn_prev_ff <= '0;
         warn_pend_ff <= '0;
         falarm_n_ff <= 1'b1;
         walarm_n_ff <= 1'b1;
      end else begin
         fault_flag_ff <= nxt_fault_flag_ff;
         warn_prev_ff <= nxt_warn_prev_ff;
         warn_pend_ff <= nxt_warn_pend_ff;
         falarm_n_ff <= nxt_falarm_n_ff;
         walarm_n_ff <= nxt_walarm_n_ff;
      end
   end

   // safe state per fault; warnings are deliberately absent here
   assign fault_act = fault_flag_ff & ~fault_mask_ff;
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_safe
         assign force_low[gi] = fault_act[gi] &&
                                safe_ff[2*gi +: 2] == fwr_pkg::SS_PULL_LOW;
         assign force_high[gi] = fault_act[gi] &&
                                 safe_ff[2*gi +: 2] == fwr_pkg::SS_PULL_HIGH;
      end
   endgenerate

   // pull low beats pull high: the safer of two conflicting choices
   always_comb begin
      if (|force_low) begin
         nxt_source_ff = 1'b0;
         nxt_sink_ff = 1'b1;
      end else if (|force_high) begin
         nxt_source_ff = 1'b1;
         nxt_sink_ff = 1'b0;
      end else begin
         nxt_source_ff = gate_cmd;
         nxt_sink_ff = !gate_cmd;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         source_ff <= 1'b0;
         sink_ff <= 1'b1;
      end else begin
         source_ff <= nxt_source_ff;
         sink_ff <= nxt_sink_ff;
      end
   end

   assign LINK.ack = ack_ff;
   assign LINK.err = err_ff;
   assign LINK.rdata = rdata_ff;
   assign LINK.fault_alarm_n = falarm_n_ff;
   assign LINK.warning_alarm_n = walarm_n_ff;
   assign SOURCE_OUTPUT_O = source_ff;
   assign SINK_OUTPUT_O = sink_ff;
   assign LINK_ENABLED_O = link_en_ff;
endmodule

/* File: verilog/fwr_pkg.sv */
package fwr_pkg;
   // link data and register index widths
   localparam int DW = 16;
   localparam int AW = 3;
   localparam int NF = 6;
   localparam int NW = 4;
   // fault positions in the fault flag word
   localparam int F_PRI_UV = 0;
   localparam int F_PRI_OV = 1;
   localparam int F_SEC_UV = 2;
   localparam int F_SEC_OV = 3;
   localparam int F_OVERCURRENT = 4;
   localparam int F_SHORT_CIRCUIT = 5;
   // device register indices on the link
   localparam logic [AW-1:0] REG_FAULT_STAT = 3'h0;
   localparam logic [AW-1:0] REG_WARN_STAT = 3'h1;
   localparam logic [AW-1:0] REG_FAULT_MASK = 3'h2;
   localparam logic [AW-1:0] REG_WARN_MASK = 3'h3;
   localparam logic [AW-1:0] REG_SAFE_STATE = 3'h4;
   localparam logic [AW-1:0] REG_CONTROL = 3'h5;
   localparam logic [AW-1:0] REG_WARN_PEND = 3'h6;
   localparam int CLR_BIT = 0;
   localparam logic [NF-1:0] FAULT_MASK_RST = 6'h00;
   localparam logic [2*NF-1:0] SAFE_STATE_RST = 12'h000;
   typedef enum logic [1:0] {
      SS_PULL_LOW = 2'h0,
      SS_PULL_HIGH = 2'h1,
      SS_IGNORE = 2'h2
   } fwr_safe_e;
   // host apb map
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_RESULT = 8'h04;
   localparam logic [7:0] A_IRQ_STAT = 8'h08;
   localparam logic [7:0] A_IRQ_MASK = 8'h0c;
   localparam logic [7:0] A_ALARM = 8'h10;
   localparam int CMD_ADDR_LSB = 16;
   localparam int CMD_WE_BIT = 24;
   localparam int RES_BUSY_BIT = 16;
   localparam int RES_ERR_BIT = 17;
   localparam int NIRQ = 3;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_WARN = 1;
   localparam int IRQ_DONE = 2;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_WAIT = 2'b10
   } fwr_hst_e;
endpackage

/* File: verilog/fwr_link_if.sv */
interface fwr_link_if;
   logic req;
   logic we;
   logic [fwr_pkg::AW-1:0] addr;
   logic [fwr_pkg::DW-1:0] wdata;
   logic [fwr_pkg::DW-1:0] rdata;
   logic ack;
   logic err;
   logic fault_alarm_n;
   logic warning_alarm_n;
   modport dev (
      input req, we, addr, wdata,
      output rdata, ack, err, fault_alarm_n, warning_alarm_n
   );
   modport host (
      output req, we, addr, wdata,
      input rdata, ack, err, fault_alarm_n, warning_alarm_n
   );
endinterface

/* File: verilog/fwr_sync.sv */
module fwr_sync #(
   parameter int W = 1
) (
   input wire logic clk_i, // core clock
   input wire logic rst_b_i, // async reset, low
   input wire logic [W-1:0] d_i, // asynchronous level
   output logic [W-1:0] q_o // synchronised level
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule

/* File: verilog/fwr_host.sv */
module fwr_host (
   input wire logic CORE_CLK_I, // core clock
   input wire logic RST_B_I, // async reset, low
   input wire logic PSEL_I, // apb select
   input wire logic PENABLE_I, // apb enable
   input wire logic PWRITE_I, // apb direction
   input wire logic [7:0] PADDR_I, // apb byte address
   input wire logic [31:0] PWDATA_I, // apb write data
   output logic [31:0] PRDATA_O, // apb read data
   output logic PREADY_O, // apb ready
   output logic PSLVERR_O, // apb error
   output logic IRQ_O, // level interrupt
   fwr_link_if.host LINK // link to the driver
);
   localparam int DW = fwr_pkg::DW;
   localparam int AW = fwr_pkg::AW;
   localparam int NIRQ = fwr_pkg::NIRQ;

   fwr_pkg::fwr_hst_e state_ff, nxt_state_ff;
   logic req_ff, nxt_req_ff;
   logic we_ff, nxt_we_ff;
   logic [AW-1:0] addr_ff, nxt_addr_ff;
   logic [DW-1:0] wdata_ff, nxt_wdata_ff;
   logic [DW-1:0] res_ff, nxt_res_ff;
   logic err_ff, nxt_err_ff;
   logic [NIRQ-1:0] stat_ff, nxt_stat_ff;
   logic [NIRQ-1:0] mask_ff, nxt_mask_ff;
   logic irq_ff, nxt_irq_ff;
   logic [1:0] alarm_prev_ff, nxt_alarm_prev_ff;
   logic [31:0] prdata_ff, nxt_prdata_ff;
   logic slverr_ff, nxt_slverr_ff;

   logic [1:0] alarm_act;
   logic setup;
   logic wr;
   logic mapped;
   logic [NIRQ-1:0] ev;

   // alarms come from device flops on this clock: no sync stage, no false edge at reset
   assign alarm_act = ~{LINK.warning_alarm_n, LINK.fault_alarm_n};

   assign setup = PSEL_I && !PENABLE_I;
   assign wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign mapped = PADDR_I == fwr_pkg::A_CMD || PADDR_I == fwr_pkg::A_RESULT ||
                   PADDR_I == fwr_pkg::A_IRQ_STAT || PADDR_I == fwr_pkg::A_IRQ_MASK ||
                   PADDR_I == fwr_pkg::A_ALARM;

   always_comb begin
      nxt_state_ff = state_ff;
      nxt_req_ff = req_ff;
      nxt_we_ff = we_ff;
      nxt_addr_ff = addr_ff;
      nxt_wdata_ff = wdata_ff;
      nxt_res_ff = res_ff;
      nxt_err_ff = err_ff;
      ev = '0;
      ev[fwr_pkg::IRQ_FAULT] = alarm_act[0] && !alarm_prev_ff[0];
      ev[fwr_pkg::IRQ_WARN] = alarm_act[1] && !alarm_prev_ff[1];
      nxt_alarm_prev_ff = alarm_act;
      case (state_ff)
         fwr_pkg::HS_IDLE: begin
            // a command written while busy is dropped
            if (wr && PADDR_I == fwr_pkg::A_CMD) begin
               nxt_req_ff = 1'b1;
               nxt_wdata_ff = PWDATA_I[DW-1:0];
               nxt_addr_ff = PWDATA_I[fwr_pkg::CMD_ADDR_LSB +: AW];
               nxt_we_ff = PWDATA_I[fwr_pkg::CMD_WE_BIT];
               nxt_state_ff = fwr_pkg::HS_WAIT;
            end
         end
         fwr_pkg::HS_WAIT: begin
            if (LINK.ack) begin
               nxt_req_ff = 1'b0;
               nxt_err_ff = LINK.err;
               if (!we_ff) begin
                  nxt_res_ff = LINK.rdata;
               end
               ev[fwr_pkg::IRQ_DONE] = 1'b1;
               nxt_state_ff = fwr_pkg::HS_IDLE;
            end
         end
         default: begin
            nxt_state_ff = fwr_pkg::HS_IDLE;
            nxt_req_ff = 1'b0;
         end
      endcase
      nxt_mask_ff = mask_ff;
      nxt_stat_ff = stat_ff;
      if (wr && PADDR_I == fwr_pkg::A_IRQ_MASK) begin
         nxt_mask_ff = PWDATA_I[NIRQ-1:0];
      end
      if (wr && PADDR_I == fwr_pkg::A_IRQ_STAT) begin
         nxt_stat_ff = stat_ff & ~PWDATA_I[NIRQ-1:0];
      end
      // a new event beats a same-cycle clear
      nxt_stat_ff = nxt_stat_ff | ev;
      nxt_irq_ff = |(nxt_stat_ff & nxt_mask_ff);
      nxt_prdata_ff = prdata_ff;
      nxt_slverr_ff = slverr_ff;
      if (setup) begin
         nxt_slverr_ff = !mapped;
         nxt_prdata_ff = '0;
         case (PADDR_I)
            fwr_pkg::A_RESULT: begin
               nxt_prdata_ff[DW-1:0] = res_ff;
               nxt_prdata_ff[fwr_pkg::RES_BUSY_BIT] = state_ff == fwr_pkg::HS_WAIT;
               nxt_prdata_ff[fwr_pkg::RES_ERR_BIT] = err_ff;
            end
            fwr_pkg::A_IRQ_STAT: nxt_prdata_ff[NIRQ-1:0] = stat_ff;
            fwr_pkg::A_IRQ_MASK: nxt_prdata_ff[NIRQ-1:0] = mask_ff;
            fwr_pkg::A_ALARM: nxt_prdata_ff[1:0] = alarm_act;
            default: nxt_prdata_ff = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_ff <= fwr_pkg::HS_IDLE;
         req_ff <= 1'b0;
         we_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
         res_ff <= '0;
         err_ff <= 1'b0;
         stat_ff <= '0;
         mask_ff <= '0;
         irq_ff <= 1'b0;
         alarm_prev_ff <= '0;
         prdata_ff <= '0;
         slverr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state_ff;
         req_ff <= nxt_req_ff;
         we_ff <= nxt_we_ff;
         addr_ff <= nxt_addr_ff;
         wdata_ff <= nxt_wdata_ff;
         res_ff <= nxt_res_ff;
         err_ff <= nxt_err_ff;
         stat_ff <= nxt_stat_ff;
         mask_ff <= nxt_mask_ff;
         irq_ff <= nxt_irq_ff;
         alarm_prev_ff <= nxt_alarm_prev_ff;
         prdata_ff <= nxt_prdata_ff;
         slverr_ff <= nxt_slverr_ff;
      end
   end

   assign LINK.req = req_ff;
   assign LINK.we = we_ff;
   assign LINK.addr = addr_ff;
   assign LINK.wdata = wdata_ff;
   assign PRDATA_O = prdata_ff;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = slverr_ff;
   assign IRQ_O = irq_ff;
endmodule

/* File: verification/fwr_chk.sv */
module fwr_chk (
   input wire logic core_clk, // core clock
   input wire logic rst_b, // async reset, low
   input wire logic req, // link request
   input wire logic we, // link direction
   input wire logic [fwr_pkg::AW-1:0] addr, // register index
   input wire logic [fwr_pkg::DW-1:0] wdata, // write data
   input wire logic [fwr_pkg::DW-1:0] rdata, // read data
   input wire logic ack, // answer pulse
   input wire logic err, // refused answer
   input wire logic fault_alarm_n, // fault alarm pin
   input wire logic warning_alarm_n // warning alarm pin
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   a_ack_follows: assert property (req && !ack |=> ack)
      else $error("no answer one cycle after a taken request");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("answer without a taken request");
   a_req_hold: assert property (req && !ack |=> req && $stable(addr)
      && $stable(we) && $stable(wdata))
      else $error("request changed before its answer");
   a_req_drop: assert property (ack |=> !req)
      else $error("request not dropped after answer");
   a_err_ack: assert property (err |-> ack)
      else $error("refusal outside an answer");
   a_err_keep: assert property (ack && err |-> $stable(rdata))
      else $error("refused request changed read data");
   a_wr_zero: assert property (ack && !err && $past(we) |-> rdata == 16'h0000)
      else $error("read data not zero after a write");
   a_rd_only: assert property ($changed(rdata) |-> ack)
      else $error("read data moved outside an answer");
   a_clr_reads0: assert property (ack && !err && !$past(we)
      && $past(addr) == fwr_pkg::REG_CONTROL |-> !rdata[fwr_pkg::CLR_BIT])
      else $error("clear command bit read back as one");
   // a mask write may also hide a pending warning, one cycle after its answer
   a_warn_release: assert property ($rose(warning_alarm_n) |-> ack && !$past(we)
      && $past(addr) == fwr_pkg::REG_WARN_STAT
      || $past(ack) && $past(we, 2) && $past(addr, 2) == fwr_pkg::REG_WARN_MASK)
      else $error("warning alarm released without a status read");

   c_refused: cover property (ack && err);
   c_read: cover property (ack && !$past(we));
   c_fault: cover property ($fell(fault_alarm_n));
   c_warn_clear: cover property ($rose(warning_alarm_n));
endmodule

/* File: verification/fault_warning_reporter_bench.sv */
module fault_warning_reporter_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, irq, src, snk, len, e;
   logic [5:0] fc = 6'h00;
   logic [3:0] wc = 4'h0;
   logic gate = 1'b0;
   logic [31:0] r;
   logic [15:0] d;
   // {safe code, gate, mask, source, sink}
   logic [5:0] tbl [4] = '{6'h09, 6'h12, 6'h2a, 6'h0e};
   int n_errors = 0;
   int total_checks = 0;

   fwr_link_if fwr_link_if_i ();
   wire fan = fwr_link_if_i.fault_alarm_n;
   wire wan = fwr_link_if_i.warning_alarm_n;
   fwr_device fwr_device_i (.CORE_CLK_I(core_clk), .RST_B_I(rst_b), .LINK(fwr_link_if_i),
      .FAULT_COND_I(fc), .WARN_COND_I(wc), .GATE_CMD_I(gate), .SOURCE_OUTPUT_O(src),
      .SINK_OUTPUT_O(snk), .LINK_ENABLED_O(len));
   fwr_host fwr_host_i (.CORE_CLK_I(core_clk), .RST_B_I(rst_b), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
      .LINK(fwr_link_if_i));
   fwr_chk fwr_chk_i (.core_clk(core_clk), .rst_b(rst_b), .req(fwr_link_if_i.req),
      .we(fwr_link_if_i.we), .addr(fwr_link_if_i.addr), .wdata(fwr_link_if_i.wdata),
      .rdata(fwr_link_if_i.rdata), .ack(fwr_link_if_i.ack), .err(fwr_link_if_i.err),
      .fault_alarm_n(fan), .warning_alarm_n(wan));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   task end_sim;
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      pen <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // one device access through the host command register, polled to completion
   task lnk(input logic w, input logic [2:0] i, input logic [15:0] wd);
      apb(1'b1, fwr_pkg::A_CMD, {7'h00, w, 5'h00, i, wd});
      do apb(1'b0, fwr_pkg::A_RESULT, 32'h00000000);
      while (r[fwr_pkg::RES_BUSY_BIT] !== 1'b0);
      d = r[15:0];
      e = r[fwr_pkg::RES_ERR_BIT];
   endtask

   // detectors pass two syncs and a flag stage, outputs one more
   task drv(input logic [5:0] f, input logic [3:0] w, input logic g);
      fc <= f;
      wc <= w;
      gate <= g;
      cyc(6);
   endtask

   task clr;
      lnk(1'b1, fwr_pkg::REG_CONTROL, 16'h0001);
      cyc(3);
   endtask

   task t_reset;
      `CHK({wan, fan}, 2'h3)
      `CHK({src, snk, len, irq}, 4'h6)
      apb(1'b0, 8'h14, 32'h00000000);
      `CHK({e, r}, 33'h100000000)
      lnk(1'b0, 3'h7, 16'h0000);
      `CHK(d, 16'h0000)
      apb(1'b1, fwr_pkg::A_IRQ_MASK, 32'h00000003);
   endtask

   task t_warn;
      drv(6'h00, 4'h1, 1'b1);
      `CHK({wan, fan, src, snk}, 4'h6)
      apb(1'b0, fwr_pkg::A_IRQ_STAT, 32'h00000000);
      `CHK(r[2:0], 3'h6)
      lnk(1'b0, fwr_pkg::REG_WARN_STAT, 16'h0000);
      `CHK({d[0], wan, irq}, 3'h7)
      lnk(1'b0, fwr_pkg::REG_WARN_STAT, 16'h0000);
      `CHK({d[0], wan}, 2'h3)
      drv(6'h00, 4'h0, 1'b1);
      drv(6'h00, 4'h1, 1'b1);
      `CHK(wan, 1'b0)
      lnk(1'b0, fwr_pkg::REG_WARN_STAT, 16'h0000);
      lnk(1'b1, fwr_pkg::REG_WARN_MASK, 16'h0001);
      drv(6'h00, 4'h0, 1'b1);
      drv(6'h00, 4'h1, 1'b1);
      `CHK(wan, 1'b1)
      lnk(1'b0, fwr_pkg::REG_WARN_PEND, 16'h0000);
      `CHK(d[0], 1'b1)
      lnk(1'b0, fwr_pkg::REG_WARN_STAT, 16'h0000);
      drv(6'h00, 4'h0, 1'b1);
      lnk(1'b1, fwr_pkg::REG_WARN_MASK, 16'h0000);
      apb(1'b1, fwr_pkg::A_IRQ_STAT, 32'h00000007);
      // the next transfer raises done, which stays masked
      lnk(1'b0, fwr_pkg::REG_WARN_STAT, 16'h0000);
      `CHK({irq, d[0]}, 2'h0)
   endtask

   task t_fault;
      drv(6'h10, 4'h0, 1'b1);
      `CHK({fan, src, snk}, 3'h1)
      apb(1'b0, fwr_pkg::A_ALARM, 32'h00000000);
      `CHK(r[1:0], 2'h1)
      clr();
      lnk(1'b0, fwr_pkg::REG_FAULT_STAT, 16'h0000);
      `CHK({fan, d[4]}, 2'h1)
      drv(6'h00, 4'h0, 1'b1);
      `CHK({fan, src}, 2'h0)
      lnk(1'b0, fwr_pkg::REG_CONTROL, 16'h0000);
      `CHK(d[0], 1'b0)
      clr();
      `CHK({fan, src, snk}, 3'h6)
      lnk(1'b0, fwr_pkg::REG_FAULT_STAT, 16'h0000);
      `CHK(d, 16'h0000)
   endtask

   task t_safe;
      for (int k = 0; k < 4; k++) begin
         lnk(1'b1, fwr_pkg::REG_SAFE_STATE, {4'h0, tbl[k][5:4], 10'h000});
         lnk(1'b1, fwr_pkg::REG_FAULT_MASK, {10'h000, tbl[k][2], 5'h00});
         drv(6'h20, 4'h0, tbl[k][3]);
         `CHK({src, snk}, tbl[k][1:0])
         `CHK(fan, tbl[k][2])
         lnk(1'b0, fwr_pkg::REG_FAULT_STAT, 16'h0000);
         `CHK(d[5], 1'b1)
         drv(6'h00, 4'h0, tbl[k][3]);
         clr();
      end
   endtask

   task t_supply;
      for (int b = 0; b < 2; b++) begin
         drv(b ? 6'h02 : 6'h01, 4'h0, 1'b1);
         `CHK({fan, src, snk, len}, 4'h2)
         lnk(1'b1, fwr_pkg::REG_WARN_MASK, 16'h000f);
         `CHK(e, 1'b1)
         drv(6'h00, 4'h0, 1'b1);
         `CHK({fan, src, len}, 3'h7)
         lnk(1'b0, fwr_pkg::REG_WARN_MASK, 16'h0000);
         `CHK(d, 16'h0000)
         drv(b ? 6'h08 : 6'h04, 4'h0, 1'b1);
         `CHK({fan, src, snk, len}, 4'h3)
         lnk(1'b0, fwr_pkg::REG_FAULT_STAT, 16'h0000);
         `CHK({e, d[3:2]}, b ? 3'h2 : 3'h1)
         drv(6'h00, 4'h0, 1'b1);
         clr();
         `CHK(fan, 1'b1)
      end
   endtask

   initial begin
      #100us;
      n_errors++;
      end_sim();
   end

   initial begin
      cyc(10);
      rst_b <= 1'b1;
      cyc(2);
      t_reset();
      t_warn();
      t_fault();
      t_safe();
      t_supply();
      end_sim();
   end
endmodule
